//--- hdl/slvl_ctrl.sv
/*
 * security lock, vector ram, key and erase control of a secure controller,
 * with the loader command gate, tamper response and power-fail handling.
 * assumes: encryptor, serial loader firmware and random source sit outside;
 * supply comparators and the tamper pin are asynchronous to sys_clk.
 */
// Function
// R1: vectors held in 48-byte on-chip ram
// R2: reset forces fetch from address zero
// R3: dummy external reads during vector fetches
// R4: hex-load vectors written into vector ram
// R5: lock command sets security lock
// R6: hardware blocks memory access while locked
// R7: unlock erases key at once
// R8: unlock erases vector ram at once
// R9: unlock then wipes external sram sequentially
// R10: unlock ends by loading fresh key
// R11: redundant lock, erase cannot be interrupted
// R12: tamper input clears lock, starts erase
// R13: tamper briefly cuts external bus supply
// R14: loader entry clears scratchpad, captures key
// R15: sram access only while lock clear
// R16: thirteen loader command letters accepted
// R17: memory commands activate new random key
// R18: key stays constant within loader session
// R19: power-fail warning interrupts to 2Bh
// R20: below minimum: reset, strobes inactive high
// R21: partition mode and peripheral space mapping
// R22: key and lock kept over power loss
// R23: unknown command letters are ignored
`timescale 1ns/100ps
`default_nettype none

module slvl_ctrl #(
	parameter int WIPE_LEN = slvl_pkg::WIPE_WORDS // shorten in simulation
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic nv_init, // backup source first applied
	input wire logic tamper_destruct_input, // async, active high
	input wire logic pfw_below, // async, supply under warning level
	input wire logic pfw_enable, // warning interrupt enable
	input wire logic vmin_below, // async, supply under minimum level
	input wire logic partition_mode_select,
	input wire logic peripheral_space_select,
	input wire logic rng_valid,
	input wire logic [7:0] rng_byte,
	input wire logic loader_entry, // pulse on loader start
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_letter,
	input wire logic vec_wr,
	input wire logic [5:0] vec_wr_addr,
	input wire logic [7:0] vec_wr_data,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_is_data,
	input wire logic mem_periph,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [16:0] ext_addr,
	output logic [7:0] ext_dout,
	output logic ext_dout_oe,
	output logic ext_ce_n,
	output logic ext_periph_ce_n,
	output logic ext_rw_n,
	output logic ext_supply_en,
	output logic [7:0] fetch_data,
	output logic fetch_valid,
	output logic cpu_pc_force,
	output logic [15:0] cpu_pc_value,
	output logic cpu_hold_reset,
	output logic pfw_irq,
	output logic [7:0] pfw_vector,
	output logic mem_grant,
	output logic mem_refused,
	output logic cmd_ack,
	output logic cmd_refused,
	output logic [7:0] cmd_fw,
	output logic locked,
	output logic erase_busy,
	output logic [63:0] key_word,
	output logic scratch_clr_we,
	output logic [6:0] scratch_clr_addr
);

	// ------------------------------------------------------------
	// state record and helpers
	// ------------------------------------------------------------
	slvl_pkg::slvl_reg_t r; // current state
	slvl_pkg::slvl_reg_t next_r; // next state

	logic [2:0] vmin_s; // power-fail minimum synchroniser
	logic [2:0] pfw_s; // power-fail warning synchroniser
	logic vmin_on; // agreed below-minimum level
	logic pfw_on; // agreed warning level
	logic tamper_on; // agreed tamper level
	logic lock_all; // every lock bit set

	// lock counts as set only while all copies agree
	function automatic logic lock_set(input logic [slvl_pkg::LOCK_BITS-1:0] l);
		lock_set = &l;
	endfunction

	// letters that need the session key before touching memory
	function automatic logic is_mem_cmd(input logic [7:0] c);
		is_mem_cmd = (c == slvl_pkg::CMD_FILL) || (c == slvl_pkg::CMD_LOAD) ||
			(c == slvl_pkg::CMD_DUMP) || (c == slvl_pkg::CMD_VERIFY) ||
			(c == slvl_pkg::CMD_CRC);
	endfunction

	// letters handed to firmware with no lock or key effect
	function automatic logic is_plain_cmd(input logic [7:0] c);
		is_plain_cmd = (c == slvl_pkg::CMD_GET) || (c == slvl_pkg::CMD_PUT) ||
			(c == slvl_pkg::CMD_RDREG) || (c == slvl_pkg::CMD_WRREG) ||
			(c == slvl_pkg::CMD_TRACE);
	endfunction

	// upper address bit: separate program/data spaces only in fixed mode
	function automatic logic bank_bit(input logic fixed_mode, input logic is_data);
		bank_bit = fixed_mode & is_data;
	endfunction

	// ------------------------------------------------------------
	// supply comparator synchronisers (no struct: restart-free on srst)
	// ------------------------------------------------------------
	// three stages each, level counts as set only while stages two and three are both set
	always_ff @(posedge sys_clk)
	begin
		vmin_s <= {vmin_s[1:0], vmin_below};
		pfw_s <= {pfw_s[1:0], pfw_below};
	end

	assign vmin_on = vmin_s[1] & vmin_s[2];
	assign pfw_on = pfw_s[1] & pfw_s[2];
	assign tamper_on = r.tsync[1] & r.tsync[2];
	assign lock_all = lock_set(r.lock);

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		// one-cycle outputs default inactive, active-low strobes high
		next_r.mem_grant = 1'b0;
		next_r.mem_refused = 1'b0;
		next_r.cmd_ack = 1'b0;
		next_r.cmd_refused = 1'b0;
		next_r.fetch_valid = 1'b0;
		next_r.ext_ce_n = 1'b1;
		next_r.ext_rw_n = 1'b1;
		next_r.ext_dout_oe = 1'b0;
		next_r.tsync = {r.tsync[1:0], tamper_destruct_input};
		next_r.tamper_seen = tamper_on;
		// free-running source for dummy addresses
		next_r.lfsr = r.lfsr[0] ? ((r.lfsr >> 1) ^ slvl_pkg::LFSR_TAPS) : (r.lfsr >> 1);

		// random bytes fill the candidate key, eight per key
		if (rng_valid && r.cand_cnt < 4'(slvl_pkg::KEY_BYTES))
		begin
			next_r.cand = {r.cand[55:0], rng_byte}; // R14
			next_r.cand_cnt = r.cand_cnt + 4'h1;
		end

		// loader start: clear scratchpad and draw a new candidate
		if (loader_entry)
		begin
			next_r.scr_cnt = 7'(slvl_pkg::SCRATCH_ZERO_BYTES); // R14
			next_r.cand_cnt = 4'h0; // R14
			next_r.key_live = 1'b0; // new session
		end
		else if (r.scr_cnt != 7'h00)
		begin
			next_r.scr_cnt = r.scr_cnt - 7'h01; // R14
		end

		// supply cut timer runs down after a tamper hit
		if (r.cut_cnt != 8'h00)
			next_r.cut_cnt = r.cut_cnt - 8'h01;

		// tamper: lock falls at once, cut supply on rising level
		if (tamper_on)
		begin
			next_r.lock = '0; // R12
			if (!r.tamper_seen)
				next_r.cut_cnt = 8'(slvl_pkg::SUPPLY_CUT_CYC); // R13
		end

		case (r.st)
			slvl_pkg::ST_IDLE:
			begin
				// lock copies that disagree (probing) or a rising tamper level start the erase
				if ((r.lock != '0 && !lock_all) || (tamper_on && !r.tamper_seen))
				begin
					next_r.lock = '0; // R11
					next_r.key = '0; // R7
					next_r.vec = '0; // R8
					next_r.key_live = 1'b0;
					next_r.wipe_addr = 16'h0000;
					next_r.cand_cnt = 4'h0;
					next_r.st = slvl_pkg::ST_WIPE; // R12
				end
				else if (cmd_valid)
				begin
					if (cmd_letter == slvl_pkg::CMD_UNLOCK || cmd_letter == slvl_pkg::CMD_SEAL)
					begin
						// seal and unlock both destroy everything
						next_r.lock = '0;
						next_r.key = '0; // R7
						next_r.vec = '0; // R8
						next_r.key_live = 1'b0;
						next_r.wipe_addr = 16'h0000;
						next_r.cand_cnt = 4'h0;
						next_r.st = slvl_pkg::ST_WIPE; // R9
						next_r.cmd_ack = 1'b1; // R16
						next_r.cmd_fw = cmd_letter;
					end
					else if (cmd_letter == slvl_pkg::CMD_LOCK)
					begin
						next_r.lock = '1; // R5
						next_r.key_live = 1'b0; // session key frozen away
						next_r.cmd_ack = 1'b1; // R16
						next_r.cmd_fw = cmd_letter;
					end
					else if (is_mem_cmd(cmd_letter))
					begin
						// refused while locked, or with no live key and no fresh candidate
						if (lock_all || (!r.key_live && r.cand_cnt != 4'(slvl_pkg::KEY_BYTES)))
							next_r.cmd_refused = 1'b1; // R15
						else
						begin
							// only the first one of a session loads the key
							if (!r.key_live)
							begin
								next_r.key = r.cand; // R17
								next_r.key_live = 1'b1; // R18
							end
							next_r.cmd_ack = 1'b1; // R16
							next_r.cmd_fw = cmd_letter;
						end
					end
					else if (is_plain_cmd(cmd_letter))
					begin
						next_r.cmd_ack = 1'b1; // R16
						next_r.cmd_fw = cmd_letter;
					end
					// other letters: no answer, nothing changes  R23
				end
			end

			slvl_pkg::ST_WIPE:
			begin
				// commands and tamper cannot stop the walk
				next_r.ext_addr = {1'b0, r.wipe_addr}; // R9
				next_r.ext_dout = 8'h00;
				next_r.ext_dout_oe = 1'b1;
				next_r.ext_ce_n = 1'b0;
				next_r.ext_rw_n = 1'b0;
				next_r.wipe_addr = r.wipe_addr + 16'h0001;
				if (32'(r.wipe_addr) == WIPE_LEN - 1)
					next_r.st = slvl_pkg::ST_REKEY; // R11
			end

			slvl_pkg::ST_REKEY:
			begin
				// waits for eight bytes drawn after the erase began
				if (r.cand_cnt == 4'(slvl_pkg::KEY_BYTES))
				begin
					next_r.key = r.cand; // R10
					next_r.cand_cnt = 4'h0;
					next_r.st = slvl_pkg::ST_IDLE;
				end
			end

			default:
			begin
				next_r.st = slvl_pkg::ST_IDLE;
			end
		endcase

		// vectors from the hex file go to on-chip ram, never sram
		if (vec_wr && r.st == slvl_pkg::ST_IDLE && !lock_all &&
			32'(vec_wr_addr) < slvl_pkg::VEC_BYTES)
			next_r.vec[vec_wr_addr] = vec_wr_data; // R4

		// bus users below the erase walk: loader memory, then fetch
		if (r.st == slvl_pkg::ST_IDLE)
		begin
			if (mem_req)
			begin
				// encryptor side also refuses, not only firmware
				if (lock_all || !r.key_live)
					next_r.mem_refused = 1'b1; // R6
				else
				begin
					next_r.mem_grant = 1'b1; // R15
					next_r.ext_addr = {bank_bit(partition_mode_select, mem_is_data),
						mem_addr}; // R21
					next_r.ext_dout = mem_wdata;
					next_r.ext_dout_oe = mem_we;
					next_r.ext_ce_n = 1'b0;
					next_r.ext_rw_n = !mem_we;
				end
			end
			else if (fetch_req || r.boot)
			begin
				next_r.boot = 1'b0;
				if (r.boot || 32'(fetch_addr) < slvl_pkg::VEC_BYTES)
				begin
					// vector fetch served inside, bus shows a decoy read
					next_r.fetch_data = r.boot ? r.vec[0] : r.vec[fetch_addr[5:0]]; // R1
					next_r.fetch_valid = 1'b1; // R2
					next_r.ext_addr = r.lfsr; // R3
					next_r.ext_ce_n = 1'b0; // R3
				end
				else
				begin
					// ordinary program fetch passes to the bus
					next_r.ext_addr = {1'b0, fetch_addr};
					next_r.ext_ce_n = 1'b0;
				end
			end
		end

		// below minimum supply every strobe is parked high
		if (vmin_on)
		begin
			next_r.ext_ce_n = 1'b1; // R20
			next_r.ext_rw_n = 1'b1; // R20
			next_r.ext_dout_oe = 1'b0;
			next_r.fetch_valid = 1'b0;
			next_r.mem_grant = 1'b0;
			next_r.boot = 1'b1; // restart at zero on recovery
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// lock, key and vectors are battery backed: srst leaves them alone
	always_ff @(posedge sys_clk)
	begin
		if (nv_init)
		begin
			r <= '0;
			r.st <= slvl_pkg::ST_IDLE;
			r.lfsr <= slvl_pkg::LFSR_SEED;
			r.ext_ce_n <= 1'b1;
			r.ext_rw_n <= 1'b1;
			r.boot <= 1'b1;
		end
		else if (srst)
		begin
			r <= next_r;
			r.lock <= next_r.lock; // R22
			r.key <= next_r.key; // R22
			r.boot <= 1'b1; // R2
			r.fetch_valid <= 1'b0;
			r.mem_grant <= 1'b0;
			r.mem_refused <= 1'b0;
			r.cmd_ack <= 1'b0;
			r.cmd_refused <= 1'b0;
			r.scr_cnt <= 7'h00;
			r.ext_ce_n <= 1'b1;
			r.ext_rw_n <= 1'b1;
			r.ext_dout_oe <= 1'b0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign ext_addr = r.ext_addr;
	assign ext_dout = r.ext_dout;
	assign ext_dout_oe = r.ext_dout_oe;
	assign ext_ce_n = r.ext_ce_n;
	assign ext_rw_n = r.ext_rw_n;
	// extra data space only when the peripheral select is on
	assign ext_periph_ce_n = !(peripheral_space_select && mem_periph && r.mem_grant); // R21
	assign ext_supply_en = (r.cut_cnt == 8'h00); // R13
	assign fetch_data = r.fetch_data;
	assign fetch_valid = r.fetch_valid;
	assign cpu_pc_force = r.boot; // R2
	assign cpu_pc_value = slvl_pkg::RESET_ADDR; // R2
	assign cpu_hold_reset = vmin_on; // R20
	// warning keeps the core running, only raises the request
	assign pfw_irq = pfw_on && pfw_enable && !vmin_on; // R19
	assign pfw_vector = slvl_pkg::PFW_VECTOR; // R19
	assign mem_grant = r.mem_grant;
	assign mem_refused = r.mem_refused;
	assign cmd_ack = r.cmd_ack;
	assign cmd_refused = r.cmd_refused;
	assign cmd_fw = r.cmd_fw;
	assign locked = lock_all;
	assign erase_busy = (r.st != slvl_pkg::ST_IDLE);
	assign key_word = r.key;
	assign scratch_clr_we = (r.scr_cnt != 7'h00);
	assign scratch_clr_addr = r.scr_cnt - 7'h01;

endmodule

`default_nettype wire

//--- include/slvl_pkg.sv
/*
 * constants, states and the state record of the secure lock, vector ram and
 * loader control block.
 * assumes: one 100 MHz clock, encryptor and random source outside the block.
 */
package slvl_pkg;

	// ------------------------------------------------------------
	// sizes and fixed values
	// ------------------------------------------------------------
	localparam int VEC_BYTES = 48; // on-chip vector ram size
	localparam logic [15:0] RESET_ADDR = 16'h0000; // logical reset address
	localparam logic [7:0] PFW_VECTOR = 8'h2b; // power-fail warning vector
	localparam int LOCK_BITS = 3; // redundant lock latch width
	localparam int KEY_BITS = 64; // encryption key width
	localparam int KEY_BYTES = 8; // random bytes per candidate key
	localparam int WIPE_WORDS = 32768; // default sram wipe length in bytes
	localparam int SCRATCH_ZERO_BYTES = 64; // loader scratchpad clear length
	localparam int SUPPLY_CUT_NS = 1000; // least supply cut on tamper
	localparam int CLK_PERIOD_NS = 10; // sys_clk period
	localparam int SUPPLY_CUT_CYC = (SUPPLY_CUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [16:0] LFSR_SEED = 17'h1_5a5a; // dummy address seed
	localparam logic [16:0] LFSR_TAPS = 17'h1_2000; // dummy address taps

	// ------------------------------------------------------------
	// loader command letters (ascii)
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_CRC = 8'h43;
	localparam logic [7:0] CMD_DUMP = 8'h44;
	localparam logic [7:0] CMD_FILL = 8'h46;
	localparam logic [7:0] CMD_GET = 8'h47;
	localparam logic [7:0] CMD_LOAD = 8'h4c;
	localparam logic [7:0] CMD_SEAL = 8'h4e;
	localparam logic [7:0] CMD_PUT = 8'h50;
	localparam logic [7:0] CMD_RDREG = 8'h52;
	localparam logic [7:0] CMD_TRACE = 8'h54;
	localparam logic [7:0] CMD_UNLOCK = 8'h55;
	localparam logic [7:0] CMD_VERIFY = 8'h56;
	localparam logic [7:0] CMD_WRREG = 8'h57;
	localparam logic [7:0] CMD_LOCK = 8'h5a;

	// ------------------------------------------------------------
	// erase sequencer states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WIPE = 3'b010,
		ST_REKEY = 3'b100
	} slvl_state_t;

	// ------------------------------------------------------------
	// whole state of the block except the supply synchronisers
	// ------------------------------------------------------------
	typedef struct packed {
		slvl_state_t st; // erase sequencer
		logic [LOCK_BITS-1:0] lock; // redundant lock latch
		logic [KEY_BITS-1:0] key; // active key
		logic [KEY_BITS-1:0] cand; // candidate key
		logic [3:0] cand_cnt; // random bytes captured
		logic key_live; // key loaded this session
		logic [VEC_BYTES-1:0][7:0] vec; // vector ram
		logic [15:0] wipe_addr; // sram wipe pointer
		logic [7:0] cut_cnt; // supply cut timer
		logic [2:0] tsync; // tamper synchroniser
		logic tamper_seen; // agreed tamper level, delayed
		logic [6:0] scr_cnt; // scratchpad clear pointer
		logic boot; // reset fetch pending
		logic [16:0] lfsr; // dummy address source
		logic [16:0] ext_addr;
		logic [7:0] ext_dout;
		logic ext_dout_oe;
		logic ext_ce_n;
		logic ext_rw_n;
		logic [7:0] fetch_data;
		logic fetch_valid;
		logic mem_grant;
		logic mem_refused;
		logic cmd_ack;
		logic cmd_refused;
		logic [7:0] cmd_fw; // command passed to firmware
	} slvl_reg_t;

endpackage

//--- testbench/slvl_ctrl_properties.sv
/*
 * concurrent checks on the ports of slvl_ctrl, bound to every instance.
 * assumes: one clock sys_clk, srst synchronous and active high.
 */
`timescale 1ns/100ps
`default_nettype none

module slvl_ctrl_properties (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic tamper_destruct_input,
	input wire logic pfw_enable,
	input wire logic vmin_below,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_letter,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic mem_req,
	input wire logic [16:0] ext_addr,
	input wire logic [7:0] ext_dout,
	input wire logic ext_dout_oe,
	input wire logic ext_ce_n,
	input wire logic ext_periph_ce_n,
	input wire logic ext_rw_n,
	input wire logic ext_supply_en,
	input wire logic fetch_valid,
	input wire logic cpu_pc_force,
	input wire logic [15:0] cpu_pc_value,
	input wire logic cpu_hold_reset,
	input wire logic pfw_irq,
	input wire logic [7:0] pfw_vector,
	input wire logic mem_grant,
	input wire logic mem_refused,
	input wire logic cmd_ack,
	input wire logic cmd_refused,
	input wire logic locked,
	input wire logic erase_busy,
	input wire logic [63:0] key_word
);
	// ----------------------------------------
	// one domain, so clock and reset given once
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	AST_RESET_FETCH: assert property ($fell(srst) |-> cpu_pc_force && cpu_pc_value == 16'h0000)
		else $error("reset fetch not pending at zero");
	// vector fetch answers inside, with a decoy read outside
	AST_VEC_DUMMY: assert property (
		fetch_req && !mem_req && !cmd_valid && fetch_addr < 16'd48 && !erase_busy
		&& !vmin_below && !cpu_hold_reset && !tamper_destruct_input
		|=> fetch_valid && !ext_ce_n && ext_rw_n)
		else $error("vector fetch without decoy read");
	AST_LOCK_SET: assert property (cmd_valid && cmd_letter == 8'h5a && !erase_busy |=> cmd_ack && locked)
		else $error("lock command did not lock");
	AST_UNLOCK_ERASE: assert property (
		cmd_valid && cmd_letter == 8'h55 && !erase_busy |=> !locked && erase_busy && key_word == 64'h0)
		else $error("unlock did not erase key");
	// a started erase stays busy for at least its first eight cycles
	AST_ERASE_HOLD: assert property ($rose(erase_busy) |-> erase_busy [*8])
		else $error("erase stopped early");
	AST_WIPE_START: assert property (
		$rose(erase_busy) && !cpu_hold_reset && ext_supply_en
		|=> !ext_ce_n && !ext_rw_n && ext_dout_oe && ext_dout == 8'h00 && ext_addr == 17'h0)
		else $error("wipe did not start at address zero");
	AST_LOCKED_REFUSE: assert property (
		mem_req && locked && !erase_busy && !cmd_valid && !tamper_destruct_input
		|=> mem_refused && !mem_grant)
		else $error("memory access granted while locked");
	AST_VMIN_STROBES: assert property (
		cpu_hold_reset && $past(cpu_hold_reset) |-> ext_ce_n && ext_periph_ce_n && ext_rw_n)
		else $error("strobe active under minimum supply");
	AST_PFW_GATE: assert property (!pfw_enable [*2] |-> !pfw_irq && pfw_vector == 8'h2b)
		else $error("warning interrupt while disabled");
	AST_TAMPER: assert property ($rose(tamper_destruct_input) |-> ##[2:8] (!locked && !ext_supply_en))
		else $error("tamper did not clear lock and cut supply");
	AST_UNKNOWN_CMD: assert property (
		cmd_valid && cmd_letter < 8'h43 && !erase_busy
		|=> !cmd_ack && !cmd_refused && $stable(locked) && $stable(key_word))
		else $error("unknown letter had an effect");
endmodule

bind slvl_ctrl slvl_ctrl_properties slvl_ctrl_properties_inst (.*);
`default_nettype wire

//--- testbench/slvl_sram_model.sv
/*
 * behavioural external sram: stores and counts write cycles.
 * assumes: active-low strobes, ext_supply_en high while the array is powered.
 */
`timescale 1ns/100ps
`default_nettype none

module slvl_sram_model (
	input wire logic sys_clk,
	input wire logic [16:0] ext_addr,
	input wire logic [7:0] ext_dout,
	input wire logic ext_dout_oe,
	input wire logic ext_ce_n,
	input wire logic ext_rw_n,
	input wire logic ext_supply_en,
	output var int n_writes,
	output var logic [16:0] last_addr
);
	logic [7:0] cells [int]; // sparse contents, no read path exists

	initial
	begin
		n_writes = 0;
		last_addr = '0;
	end

	// ----------------------------------------
	// write capture; unpowered cells lose all
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (ext_supply_en !== 1'b1)
			cells.delete();
		else if (ext_ce_n === 1'b0 && ext_rw_n === 1'b0 && ext_dout_oe === 1'b1)
		begin
			cells[ext_addr] = ext_dout;
			n_writes++;
			last_addr = ext_addr;
		end
	end
endmodule
`default_nettype wire

//--- testbench/slvl_ctrl_bench.sv
/*
 * self-checking bench of slvl_ctrl with a short wipe length.
 * assumes: slvl_pkg, the sram model and the checker compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module slvl_ctrl_bench;
	localparam int WL = 16; // short wipe keeps the run small
	logic sys_clk = 1'b0, srst, nv_init, tamper_destruct_input, pfw_below, pfw_enable;
	logic vmin_below, partition_mode_select, peripheral_space_select, rng_valid, loader_entry;
	logic cmd_valid, vec_wr, fetch_req, mem_req, mem_we, mem_is_data, mem_periph;
	logic [7:0] rng_byte, cmd_letter, vec_wr_data, mem_wdata, ext_dout, fetch_data, pfw_vector, cmd_fw;
	logic [5:0] vec_wr_addr;
	logic [15:0] fetch_addr, mem_addr, cpu_pc_value, a;
	logic [16:0] ext_addr, last_addr;
	logic ext_dout_oe, ext_ce_n, ext_periph_ce_n, ext_rw_n, ext_supply_en, fetch_valid, cpu_pc_force;
	logic cpu_hold_reset, pfw_irq, mem_grant, mem_refused, cmd_ack, cmd_refused, locked, erase_busy;
	logic scratch_clr_we;
	logic [6:0] scratch_clr_addr;
	logic [63:0] key_word, kexp; // kexp: key built from fed bytes
	logic [7:0] vexp [48]; // vector contents written
	int n_writes, w0, mismatches = 0, n_tests = 0, seed = 32;
	string s = "CDFGLPRTVW"; // accepted letters that keep the lock open

	slvl_ctrl #(.WIPE_LEN(WL)) slvl_ctrl_inst (.*);
	slvl_sram_model slvl_sram_model_inst (.*);

	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// wide enough for flag bits packed beside the whole key
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// inputs always move 1 ns after the edge
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic cmd(input logic [7:0] l);
		step; // one idle edge, so the strobe never drops and rises at once
		cmd_valid = 1'b1;
		cmd_letter = l;
		step;
		cmd_valid = 1'b0;
	endtask

	task automatic mem(input logic we, input logic [15:0] adr);
		step; // idle edge between requests
		mem_req = 1'b1;
		mem_we = we;
		mem_addr = adr;
		mem_wdata = 8'($random(seed));
		step;
		mem_req = 1'b0;
	endtask

	task automatic fetch(input logic [15:0] adr);
		step; // idle edge between requests
		fetch_req = 1'b1;
		fetch_addr = adr;
		step;
		fetch_req = 1'b0;
	endtask

	// first byte fed ends in the top of the key
	task automatic feed;
		repeat (8)
		begin
			rng_byte = 8'($random(seed));
			rng_valid = 1'b1;
			kexp = {kexp[55:0], rng_byte};
			step;
		end
		rng_valid = 1'b0;
	endtask

	// bounded wait for the erase sequencer
	task automatic idle;
		for (int i = 0; i < 400 && erase_busy !== 1'b0; i++)
			step;
		if (erase_busy !== 1'b0)
		begin
			mismatches++;
			final_report;
		end
	endtask

	task automatic erase(input logic [7:0] l);
		w0 = n_writes;
		cmd(l);
		chk({cmd_ack, locked, erase_busy}, 3'b101);
		chk(key_word, 64'h0);
		feed;
		idle;
		chk(n_writes - w0, WL);
		chk(last_addr, WL - 1);
		chk(key_word, kexp);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{srst, nv_init, tamper_destruct_input, pfw_below, pfw_enable, vmin_below} = 6'h30;
		{partition_mode_select, peripheral_space_select, rng_valid, loader_entry} = 4'h0;
		{cmd_valid, vec_wr, fetch_req, mem_req, mem_we, mem_is_data, mem_periph} = 7'h00;
		{rng_byte, cmd_letter, vec_wr_addr, vec_wr_data, fetch_addr, mem_addr, mem_wdata} = '0;
		kexp = '0;
		repeat (20) step;
		{srst, nv_init} = 2'b00;
		chk({locked, cpu_pc_force, cpu_pc_value}, {2'b01, 16'h0000});
		step;
		// pending reset fetch served from vector ram, decoy read outside
		chk({cpu_pc_force, fetch_valid, fetch_data, ext_ce_n, ext_rw_n}, 12'h401);
		// fill vector ram, then read it back through fetches
		for (int i = 0; i < 48; i++)
		begin
			vec_wr = 1'b1;
			vec_wr_addr = 6'(i);
			vec_wr_data = 8'($random(seed));
			vexp[i] = vec_wr_data;
			step;
		end
		vec_wr = 1'b0;
		for (int i = 0; i < 48; i++)
		begin
			fetch(16'(i));
			chk({fetch_valid, fetch_data, ext_ce_n, ext_rw_n}, {1'b1, vexp[i], 2'b01});
		end
		loader_entry = 1'b1;
		step;
		loader_entry = 1'b0;
		chk({scratch_clr_we, scratch_clr_addr}, {1'b1, 7'h3f});
		cmd(slvl_pkg::CMD_FILL);
		chk({cmd_ack, cmd_refused}, 2'b01);
		feed;
		cmd(slvl_pkg::CMD_FILL);
		chk({cmd_ack, key_word}, {1'b1, kexp});
		cmd(8'h41);
		chk({cmd_ack, cmd_refused, locked, key_word}, {3'b000, kexp});
		for (int i = 0; i < 10; i++)
		begin
			cmd(s[i]);
			chk({cmd_ack, key_word}, {1'b1, kexp});
			chk(cmd_fw, s[i]);
		end
		mem_is_data = 1'b1;
		partition_mode_select = 1'b1;
		mem(1'b1, 16'h0123);
		chk({mem_grant, ext_addr, ext_ce_n, ext_rw_n, ext_dout_oe}, {18'h30123, 3'b001});
		chk(ext_dout, mem_wdata);
		partition_mode_select = 1'b0;
		mem(1'b0, 16'h0456);
		chk({mem_grant, ext_addr, ext_rw_n}, {18'h20456, 1'b1});
		{peripheral_space_select, mem_periph} = 2'b11;
		mem(1'b0, 16'h0040);
		chk(ext_periph_ce_n, 1'b0);
		mem_periph = 1'b0;
		cmd(slvl_pkg::CMD_LOCK);
		chk({cmd_ack, locked}, 2'b11);
		cmd(slvl_pkg::CMD_DUMP);
		chk(cmd_refused, 1'b1);
		mem(1'b0, 16'h0010);
		chk({mem_grant, mem_refused}, 2'b01);
		srst = 1'b1;
		step;
		srst = 1'b0;
		step;
		chk({locked, key_word}, {1'b1, kexp});
		erase(slvl_pkg::CMD_UNLOCK);
		fetch(16'd5);
		chk({fetch_valid, fetch_data}, 9'h100);
		erase(slvl_pkg::CMD_SEAL);
		cmd(slvl_pkg::CMD_LOCK);
		tamper_destruct_input = 1'b1;
		repeat (6) step;
		chk({locked, erase_busy, ext_supply_en}, 3'b010);
		tamper_destruct_input = 1'b0;
		feed;
		idle;
		chk(key_word, kexp);
		repeat (100) step;
		chk(ext_supply_en, 1'b1);
		{pfw_below, pfw_enable} = 2'b11;
		repeat (4) step;
		chk({pfw_irq, pfw_vector, cpu_hold_reset}, {1'b1, 8'h2b, 1'b0});
		pfw_enable = 1'b0;
		repeat (4) step;
		chk(pfw_irq, 1'b0);
		vmin_below = 1'b1;
		fetch_req = 1'b1;
		repeat (4) step;
		chk({cpu_hold_reset, cpu_pc_force, ext_ce_n, ext_periph_ce_n, ext_rw_n}, 5'h1f);
		{vmin_below, fetch_req, pfw_below} = 3'b000;
		// reset fetch stays pending until the supply level settles
		step;
		fetch(16'h0300);
		chk({fetch_valid, fetch_data}, 9'h100);
		// random mix of vector and external fetches
		repeat (40)
		begin
			a = 16'($random(seed));
			if (a[0])
				a = a % 16'd48;
			fetch(a);
			if (a < 16'd48)
				chk({fetch_valid, fetch_data, ext_ce_n, ext_rw_n}, 11'h401);
			else
				chk({ext_ce_n, ext_rw_n, ext_addr[15:0]}, {2'b01, a});
		end
		final_report;
	end
endmodule
`default_nettype wire
